// File: rtl/aid_defines.vh
// constants for the arithmetic instruction decoder and sequencer
// assumes one 200 MHz core clock and a synchronous-read program memory
`ifndef AID_DEFINES_VH
`define AID_DEFINES_VH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
// divider end count, 6 clocks a cycle
`define AID_ICYC_LAST 3'h5

// ----------------------------------------------------------------
// status word field positions
// ----------------------------------------------------------------
`define AID_PSW_CY 7
`define AID_PSW_AC 6
`define AID_PSW_RS1 4
`define AID_PSW_RS0 3
`define AID_PSW_OV 2
`define AID_PSW_P 0

// ----------------------------------------------------------------
// registers reachable by direct forms
// ----------------------------------------------------------------
`define AID_SFR_ACC 8'hE0
`define AID_SFR_B 8'hF0
`define AID_SFR_PSW 8'hD0
`define AID_SFR_DPL 8'h82
`define AID_SFR_DPH 8'h83

// ----------------------------------------------------------------
// opcode encodings
// ----------------------------------------------------------------
`define AID_HI_INC 4'h0
`define AID_HI_DEC 4'h1
`define AID_HI_ADD 4'h2
`define AID_HI_ADCY 4'h3
`define AID_HI_SBRW 4'h9
`define AID_LO_FIRST 4'h4
`define AID_OPC_INCDP 8'hA3
`define AID_OPC_MUL 8'hA4
`define AID_OPC_DIV 8'h84
`define AID_OPC_DA 8'hD4

// ----------------------------------------------------------------
// instruction cycle counts
// ----------------------------------------------------------------
`define AID_NCYC_ONE 3'h1
`define AID_NCYC_TWO 3'h2
`define AID_NCYC_INCDP 3'h3
`define AID_NCYC_MULDIV 3'h5

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define AID_RST_BYTE 8'h00
`define AID_RST_WORD 16'h0000

`endif

// File: rtl/aid_iram.v
// internal data memory, 256 bytes, one write and one read port
// assumes the sequencer gives the read address one clock before use
`timescale 1ns/10ps

module aid_iram (
    // clock and reset
    input wire clock,
    input wire arst_n,
    // write side
    input wire wrEn,
    input wire [7:0] wrAddr,
    input wire [7:0] wrData,
    // read side
    input wire [7:0] rdAddr,
    output reg [7:0] rdData
);

    reg [7:0] mem [0:255];

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    // no reset on the array so it maps onto plain ram
    always @(posedge clock) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
    end

    // registered read; same-address write returns the old byte
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rdData <= 8'h00;
        end else begin
            rdData <= mem[rdAddr];
        end
    end

endmodule // aid_iram

// File: rtl/aid_arith_decode.v
// decoder and sequencer for the arithmetic instruction group
// assumes program memory returns the byte at progAddr one clock later,
// and that preloads happen only while run is low and the core is idle
`timescale 1ns/10ps
`include "aid_defines.vh"

// Operation
// RULE1 - standard opcodes, same function, own timing
// RULE2 - flags updated exactly as standard part
// RULE3 - indirect address from R0/R1 by bit0
// RULE4 - 25: add direct byte, 2 bytes/cycles
// RULE5 - 26-27: add indirect byte, one cycle
// RULE6 - 38-3F: add register plus carry
// RULE7 - 35: add direct plus carry, two cycles
// RULE8 - 36-37: add indirect plus carry, one cycle
// RULE9 - 34: add immediate plus carry, two cycles
// RULE10 - 98-9F: subtract register with borrow
// RULE11 - 95: subtract direct with borrow, two cycles
// RULE12 - 96-97: subtract indirect with borrow
// RULE13 - 94: subtract immediate with borrow
// RULE14 - 05: increment direct byte in place
// RULE15 - 06-07: increment indirect byte in place
// RULE16 - 15: decrement direct byte in place
// RULE17 - 16-17: decrement indirect byte in place
// RULE18 - A3: increment data pointer, three cycles
// RULE19 - register add one cycle, immediate two
// RULE20 - accumulator/register increment, decrement single cycle
// RULE21 - multiply and divide take five cycles
// RULE22 - decimal adjust in one cycle
module aid_arith_decode (
    // clock and reset
    input wire clock,
    input wire arst_n,
    // run control
    input wire run,
    // program memory
    output reg [15:0] progAddr,
    input wire [7:0] progData,
    // preload while halted
    input wire ramLoadEn,
    input wire [7:0] ramLoadAddr,
    input wire [7:0] ramLoadData,
    input wire regLoadEn,
    input wire [7:0] regLoadAcc,
    input wire [7:0] regLoadB,
    input wire [7:0] regLoadPsw,
    input wire [15:0] regLoadPointer,
    // architectural state
    output reg [7:0] acc,
    output reg [7:0] bReg,
    output reg [7:0] psw,
    output reg [15:0] dataPointer16,
    // sequencing
    output reg instrDone,
    output reg unsupportedOp
);

    // ----------------------------------------------------------------
    // encodings
    // ----------------------------------------------------------------
    localparam ST_IDLE = 3'h0;
    localparam ST_FETCH = 3'h1;
    localparam ST_OPWAIT = 3'h2;
    localparam ST_OPND = 3'h3;
    localparam ST_PTR = 3'h4;
    localparam ST_MEM = 3'h5;
    localparam ST_EXEC = 3'h6;
    localparam ST_WAIT = 3'h7;

    localparam SRC_NONE = 3'h0;
    localparam SRC_A = 3'h1;
    localparam SRC_IMM = 3'h2;
    localparam SRC_DIR = 3'h3;
    localparam SRC_IND = 3'h4;
    localparam SRC_REG = 3'h5;

    localparam OP_NONE = 4'h0;
    localparam OP_ADD = 4'h1;
    localparam OP_ADCY = 4'h2;
    localparam OP_SBRW = 4'h3;
    localparam OP_INC = 4'h4;
    localparam OP_DEC = 4'h5;
    localparam OP_INCDP = 4'h6;
    localparam OP_MUL = 4'h7;
    localparam OP_DIV = 4'h8;
    localparam OP_DA = 4'h9;

    reg [2:0] state;
    reg [2:0] divCnt;
    reg [2:0] cycLeft;
    reg [7:0] opcode;
    reg [7:0] operand;
    reg [7:0] memAddr;
    reg isSfr;
    wire [7:0] ramRdata;
    wire icycTick = (divCnt == `AID_ICYC_LAST);

    // ----------------------------------------------------------------
    // instruction cycle divider
    // ----------------------------------------------------------------
    // free running so every instruction starts on a cycle boundary
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            divCnt <= 3'h0;
        end else if (icycTick) begin
            divCnt <= 3'h0;
        end else begin
            divCnt <= divCnt + 3'h1;
        end
    end

    // ----------------------------------------------------------------
    // opcode decode
    // ----------------------------------------------------------------
    // the opcode is live on progData in fetch, held afterwards
    wire [7:0] decByte = (state == ST_FETCH) ? progData : opcode;
    reg [3:0] decOp;
    reg [2:0] decSrc;
    reg [2:0] decCyc;
    reg decTwoByte;

    always @* begin
        decOp = OP_NONE;
        decSrc = SRC_NONE;
        if (decByte[3:0] >= `AID_LO_FIRST) begin
            case (decByte[7:4])
                `AID_HI_INC: decOp = OP_INC; // RULE14 RULE15 RULE20
                `AID_HI_DEC: decOp = OP_DEC; // RULE16 RULE17 RULE20
                `AID_HI_ADD: decOp = OP_ADD; // RULE4 RULE5 RULE19
                `AID_HI_ADCY: decOp = OP_ADCY; // RULE6 RULE7 RULE8 RULE9
                `AID_HI_SBRW: decOp = OP_SBRW; // RULE10 RULE11 RULE12 RULE13
                default: decOp = OP_NONE;
            endcase
            // operand form comes from the low nibble; x4 is the accumulator for inc/dec, else immediate
            if (decOp != OP_NONE) begin
                if (decByte[3]) begin
                    decSrc = SRC_REG; // RULE6 RULE10 RULE19 RULE20
                end else if (decByte[2:1] == 2'h3) begin
                    decSrc = SRC_IND; // RULE5 RULE8 RULE12 RULE15 RULE17
                end else if (decByte[0]) begin
                    decSrc = SRC_DIR; // RULE4 RULE7 RULE11 RULE14 RULE16
                end else if ((decOp == OP_INC) || (decOp == OP_DEC)) begin
                    decSrc = SRC_A; // RULE20
                end else begin
                    decSrc = SRC_IMM; // RULE9 RULE13 RULE19
                end
            end
        end
        case (decByte)
            `AID_OPC_INCDP: decOp = OP_INCDP; // RULE18
            `AID_OPC_MUL: decOp = OP_MUL; // RULE21
            `AID_OPC_DIV: decOp = OP_DIV; // RULE21
            `AID_OPC_DA: decOp = OP_DA; // RULE22
            default: decOp = decOp;
        endcase
        decTwoByte = (decSrc == SRC_DIR) || (decSrc == SRC_IMM);
        if (decOp == OP_INCDP) begin
            decCyc = `AID_NCYC_INCDP; // RULE18
        end else if ((decOp == OP_MUL) || (decOp == OP_DIV)) begin
            decCyc = `AID_NCYC_MULDIV; // RULE21
        end else if (decTwoByte) begin
            decCyc = `AID_NCYC_TWO; // RULE4 RULE7 RULE9 RULE11 RULE13
        end else begin
            decCyc = `AID_NCYC_ONE; // RULE5 RULE8 RULE12 RULE22
        end
    end

    // ----------------------------------------------------------------
    // internal memory port
    // ----------------------------------------------------------------
    // bank bits pick one of four register banks
    wire [7:0] regAddr = {3'h0, psw[`AID_PSW_RS1:`AID_PSW_RS0], decByte[2:0]};
    wire [7:0] ptrAddr = {3'h0, psw[`AID_PSW_RS1:`AID_PSW_RS0], 2'h0, decByte[0]}; // RULE3
    reg [7:0] ramRdAddr;
    reg execWr;
    reg [7:0] execWrData;

    always @* begin
        case (state)
            ST_FETCH: ramRdAddr = (decSrc == SRC_IND) ? ptrAddr : regAddr;
            ST_OPND: ramRdAddr = progData;
            ST_PTR: ramRdAddr = ramRdata; // RULE3
            default: ramRdAddr = 8'h00;
        endcase
    end

    // preload shares the write port; only legal while idle
    wire ramWe = ((state == ST_EXEC) && execWr && !isSfr)
        || ((state == ST_IDLE) && ramLoadEn);
    wire [7:0] ramWrAddr = (state == ST_EXEC) ? memAddr : ramLoadAddr;
    wire [7:0] ramWrData = (state == ST_EXEC) ? execWrData : ramLoadData;

    aid_iram u_iram (
        .clock(clock),
        .arst_n(arst_n),
        .wrEn(ramWe),
        .wrAddr(ramWrAddr),
        .wrData(ramWrData),
        .rdAddr(ramRdAddr),
        .rdData(ramRdata)
    );

    // direct addresses above 0x7F reach the few registers held here
    reg [7:0] sfrRead;
    always @* begin
        case (memAddr)
            `AID_SFR_ACC: sfrRead = acc;
            `AID_SFR_B: sfrRead = bReg;
            `AID_SFR_PSW: sfrRead = psw;
            `AID_SFR_DPL: sfrRead = dataPointer16[7:0];
            `AID_SFR_DPH: sfrRead = dataPointer16[15:8];
            default: sfrRead = 8'h00;
        endcase
    end

    // ----------------------------------------------------------------
    // execute datapath
    // ----------------------------------------------------------------
    wire cin = ((decOp == OP_ADCY) || (decOp == OP_SBRW)) ? psw[`AID_PSW_CY] : 1'b0;
    wire [8:0] sum9 = {1'b0, acc} + {1'b0, operand} + {8'h00, cin};
    wire [4:0] sumNib = {1'b0, acc[3:0]} + {1'b0, operand[3:0]} + {4'h0, cin};
    wire [8:0] dif9 = {1'b0, acc} - {1'b0, operand} - {8'h00, cin};
    wire [4:0] difNib = {1'b0, acc[3:0]} - {1'b0, operand[3:0]} - {4'h0, cin};
    wire [15:0] prod = {8'h00, acc} * {8'h00, bReg};
    wire [7:0] stepIn = (decSrc == SRC_A) ? acc : operand;
    wire [7:0] stepOut = (decOp == OP_INC) ? stepIn + 8'h01 : stepIn - 8'h01;
    wire daLow = (acc[3:0] > 4'h9) || psw[`AID_PSW_AC];
    wire [8:0] daT1 = {1'b0, acc} + (daLow ? 9'h006 : 9'h000);
    wire daHigh = (daT1[7:4] > 4'h9) || psw[`AID_PSW_CY] || daT1[8];
    wire [8:0] daT2 = {1'b0, daT1[7:0]} + (daHigh ? 9'h060 : 9'h000);
    reg [7:0] nAcc;
    reg [7:0] nB;
    reg [7:0] nPsw;
    reg [15:0] nPtr;

    always @* begin
        nAcc = acc;
        nB = bReg;
        nPsw = psw;
        nPtr = dataPointer16;
        execWr = 1'b0;
        execWrData = 8'h00;
        case (decOp)
            OP_ADD, OP_ADCY: begin
                nAcc = sum9[7:0]; // RULE4 RULE5 RULE6 RULE7 RULE8 RULE9
                nPsw[`AID_PSW_CY] = sum9[8]; // RULE2
                nPsw[`AID_PSW_AC] = sumNib[4]; // RULE2
                nPsw[`AID_PSW_OV] = (acc[7] == operand[7]) && (sum9[7] != acc[7]); // RULE2
            end
            OP_SBRW: begin
                nAcc = dif9[7:0]; // RULE10 RULE11 RULE12 RULE13
                nPsw[`AID_PSW_CY] = dif9[8]; // RULE2
                nPsw[`AID_PSW_AC] = difNib[4]; // RULE2
                nPsw[`AID_PSW_OV] = (acc[7] != operand[7]) && (dif9[7] != acc[7]); // RULE2
            end
            OP_INC, OP_DEC: begin
                // no flags change; only the parity follows the accumulator
                if (decSrc == SRC_A) begin
                    nAcc = stepOut; // RULE20
                end else begin
                    execWr = 1'b1; // RULE14 RULE15 RULE16 RULE17
                    execWrData = stepOut;
                end
            end
            OP_INCDP: nPtr = dataPointer16 + 16'h0001; // RULE18
            OP_MUL: begin
                nAcc = prod[7:0]; // RULE21
                nB = prod[15:8];
                nPsw[`AID_PSW_CY] = 1'b0; // RULE2
                nPsw[`AID_PSW_OV] = |prod[15:8]; // RULE2
            end
            OP_DIV: begin
                nPsw[`AID_PSW_CY] = 1'b0; // RULE2
                nPsw[`AID_PSW_OV] = (bReg == 8'h00); // RULE2
                // divide by zero leaves both operands untouched
                if (bReg != 8'h00) begin
                    nAcc = acc / bReg; // RULE21
                    nB = acc % bReg;
                end
            end
            OP_DA: begin
                nAcc = daT2[7:0]; // RULE22
                nPsw[`AID_PSW_CY] = psw[`AID_PSW_CY] | daT1[8] | daT2[8]; // RULE2
            end
            default: nAcc = acc;
        endcase
        // in-place update of a register held here rather than in ram
        if (execWr && isSfr) begin
            case (memAddr)
                `AID_SFR_ACC: nAcc = execWrData;
                `AID_SFR_B: nB = execWrData;
                `AID_SFR_PSW: nPsw = execWrData;
                `AID_SFR_DPL: nPtr[7:0] = execWrData;
                `AID_SFR_DPH: nPtr[15:8] = execWrData;
                default: nB = nB;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // sequencer and architectural state
    // ----------------------------------------------------------------
    // opcodes outside the group run as one-byte one-cycle no-ops
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_IDLE;
            cycLeft <= `AID_NCYC_ONE;
            opcode <= `AID_RST_BYTE;
            operand <= `AID_RST_BYTE;
            memAddr <= `AID_RST_BYTE;
            isSfr <= 1'b0;
            progAddr <= `AID_RST_WORD;
            acc <= `AID_RST_BYTE;
            bReg <= `AID_RST_BYTE;
            psw <= `AID_RST_BYTE;
            dataPointer16 <= `AID_RST_WORD;
            instrDone <= 1'b0;
            unsupportedOp <= 1'b0;
        end else begin
            instrDone <= 1'b0;
            unsupportedOp <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (regLoadEn) begin
                        acc <= regLoadAcc;
                        bReg <= regLoadB;
                        psw <= {regLoadPsw[7:1], ^regLoadAcc};
                        dataPointer16 <= regLoadPointer;
                    end
                    if (run && icycTick) begin
                        state <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    opcode <= progData; // RULE1
                    progAddr <= progAddr + 16'h0001;
                    cycLeft <= decCyc;
                    isSfr <= 1'b0;
                    memAddr <= regAddr;
                    if (decOp == OP_NONE) begin
                        unsupportedOp <= 1'b1;
                        state <= ST_WAIT;
                    end else if (decTwoByte) begin
                        state <= ST_OPWAIT;
                    end else if (decSrc == SRC_IND) begin
                        state <= ST_PTR;
                    end else if (decSrc == SRC_REG) begin
                        state <= ST_MEM;
                    end else begin
                        state <= ST_EXEC;
                    end
                end
                ST_OPWAIT: state <= ST_OPND;
                ST_OPND: begin
                    operand <= progData;
                    progAddr <= progAddr + 16'h0001;
                    memAddr <= progData;
                    isSfr <= progData[7];
                    state <= (decSrc == SRC_IMM) ? ST_EXEC : ST_MEM;
                end
                ST_PTR: begin
                    memAddr <= ramRdata; // RULE3
                    state <= ST_MEM;
                end
                ST_MEM: begin
                    operand <= isSfr ? sfrRead : ramRdata;
                    state <= ST_EXEC;
                end
                ST_EXEC: begin
                    acc <= nAcc;
                    bReg <= nB;
                    psw <= {nPsw[7:1], ^nAcc}; // RULE2
                    dataPointer16 <= nPtr;
                    state <= ST_WAIT;
                end
                ST_WAIT: begin
                    // hold until the instruction has used all its cycles
                    if (icycTick) begin
                        if (cycLeft == `AID_NCYC_ONE) begin
                            instrDone <= 1'b1;
                            state <= run ? ST_FETCH : ST_IDLE;
                        end else begin
                            cycLeft <= cycLeft - 3'h1;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

endmodule // aid_arith_decode

// File: dv/aid_arith_asserts.sv
// checker for the arithmetic decoder, bound to the core's ports
// assumes one core clock and the active-low asynchronous reset
`timescale 1ns/10ps

module aid_arith_asserts (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // preload strobe
    input wire logic regLoadEn,
    // outputs watched
    input wire logic [15:0] progAddr,
    input wire logic [7:0] acc,
    input wire logic [7:0] psw,
    input wire logic [15:0] dataPointer16,
    input wire logic instrDone,
    input wire logic unsupportedOp
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    logic [2:0] phase;
    logic seenDone;

    // clocks since last end pulse, modulo 6
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            phase <= 3'h0;
            seenDone <= 1'b0;
        end else begin
            phase <= (instrDone || phase == 3'h5) ? 3'h0 : phase + 3'h1;
            seenDone <= seenDone | instrDone;
        end
    end

    // at most one end per 6 clocks
    sequence s_quiet5;
        !instrDone [*5];
    endsequence
    // unsupported opcode ends within one cycle
    sequence s_end_soon;
        ##[0:6] instrDone;
    endsequence

    a_done_spacing: assert property (instrDone |=> s_quiet5)
        else $error("end pulse too soon");
    a_whole_cycles: assert property (instrDone && seenDone |-> phase == 3'h5)
        else $error("length not whole cycles");
    a_unsup_ends: assert property (unsupportedOp |-> s_end_soon)
        else $error("unsupported op did not end");
    a_unsup_pulse: assert property (unsupportedOp |=> !unsupportedOp)
        else $error("unsupported pulse too long");
    a_parity_end: assert property (instrDone |-> psw[0] == ^acc)
        else $error("parity wrong");
    a_pc_step_one: assert property ($changed(progAddr) |-> progAddr == $past(progAddr) + 16'h0001)
        else $error("program address jumped");
    a_pc_held_end: assert property (instrDone |-> $stable(progAddr))
        else $error("program address moving at end");
    a_pointer_step: assert property ($changed(dataPointer16) && !$past(regLoadEn)
        |-> dataPointer16 == $past(dataPointer16) + 16'h0001)
        else $error("data pointer jumped");
    a_reset_clean: assert property (!$past(arst_n) |-> progAddr == 16'h0000 && acc == 8'h00
        && !instrDone)
        else $error("state not reset");
endmodule // aid_arith_asserts

bind aid_arith_decode aid_arith_asserts u_chk (.clock(clock), .arst_n(arst_n),
    .regLoadEn(regLoadEn), .progAddr(progAddr), .acc(acc), .psw(psw),
    .dataPointer16(dataPointer16), .instrDone(instrDone), .unsupportedOp(unsupportedOp));

// File: dv/aid_prog_rom.sv
// program memory model, 256 bytes, synchronous read
// assumes the bench writes mem only while the core is stopped
`timescale 1ns/10ps

module aid_prog_rom (
    // clock
    input wire logic clock,
    // fetch port
    input wire logic [15:0] progAddr,
    output logic [7:0] progData
);
    logic [7:0] mem [0:255];

    // unwritten bytes hold 00, which the core treats as outside its group
    initial begin
        foreach (mem[i]) begin
            mem[i] = 8'h00;
        end
        progData = 8'h00;
    end

    // one clock of read latency, as the core expects
    always @(posedge clock) begin
        progData <= mem[progAddr[7:0]];
    end
endmodule // aid_prog_rom

// File: dv/aid_arith_decode_bench.sv
// self-checking bench for the arithmetic decoder and sequencer
// assumes the program memory model; the checker is bound to the core
`timescale 1ns/10ps

module aid_arith_decode_bench;
    logic clock;
    logic arst_n;
    logic run;
    logic ramLoadEn;
    logic [7:0] ramLoadAddr;
    logic [7:0] ramLoadData;
    logic regLoadEn;
    logic [7:0] regLoadAcc;
    logic [7:0] regLoadB;
    logic [7:0] regLoadPsw;
    logic [15:0] regLoadPointer;
    wire [15:0] progAddr;
    wire [7:0] progData;
    wire [7:0] acc;
    wire [7:0] bReg;
    wire [7:0] psw;
    wire [15:0] dataPointer16;
    wire instrDone;
    wire unsupportedOp;
    int numErrors = 0;
    int nChecks = 0;
    int cyc = 0;
    int nUnsup = 0;
    logic [15:0] pc = 16'h0000;
    logic [7:0] eB = 8'h03;
    logic [15:0] eDp = 16'h12FF;

    aid_arith_decode DUT (.clock(clock), .arst_n(arst_n), .run(run), .progAddr(progAddr),
        .progData(progData), .ramLoadEn(ramLoadEn), .ramLoadAddr(ramLoadAddr),
        .ramLoadData(ramLoadData), .regLoadEn(regLoadEn), .regLoadAcc(regLoadAcc),
        .regLoadB(regLoadB), .regLoadPsw(regLoadPsw), .regLoadPointer(regLoadPointer),
        .acc(acc), .bReg(bReg), .psw(psw), .dataPointer16(dataPointer16),
        .instrDone(instrDone), .unsupportedOp(unsupportedOp));
    aid_prog_rom rom (.clock(clock), .progAddr(progAddr), .progData(progData));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // about 900 clocks needed; 8000 means a hang
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            numErrors++;
            closeOut();
        end
    end

    // count unsupported pulses
    always @(negedge clock) begin
        if (unsupportedOp === 1'b1) nUnsup++;
    end

    task automatic closeOut();
        $display("checks %0d mismatches %0d", nChecks, numErrors);
        if (numErrors == 0 && nChecks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, exp);
        nChecks++;
        if (seen !== exp) begin
            numErrors++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic waitDone(output int t);
        for (int k = 0; k < 64; k++) begin
            @(negedge clock);
            if (instrDone === 1'b1) break;
        end
        t = cyc;
        check("instrDone", {31'h0, instrDone}, 32'h1);
    endtask

    // ----
    // filler byte, then one instruction; gap between ends is its length
    // ----
    task automatic exec(input logic [7:0] opc, opnd, input int nb, nc,
        input logic [7:0] ea, ep);
        int t0;
        int t1;
        int u0;
        rom.mem[pc[7:0]] = 8'h00;
        rom.mem[pc[7:0] + 8'h01] = opc;
        rom.mem[pc[7:0] + 8'h02] = opnd;
        u0 = nUnsup;
        run = 1'b1;
        waitDone(t0);
        repeat (2) @(negedge clock);
        run = 1'b0;
        waitDone(t1);
        pc = pc + 16'(nb + 1);
        check("cycles", t1 - t0, 6 * nc);
        check("progAddr", progAddr, pc);
        check("acc", acc, ea);
        check("psw", psw, ep);
        check("bReg", bReg, eB);
        check("dataPointer16", dataPointer16, eDp);
        check("unsupported", nUnsup - u0, (opc == 8'hE4) ? 2 : 1);
    endtask

    task automatic tPreload();
        logic [7:0] ra [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h30, 8'h40, 8'h41};
        logic [7:0] rd [7] = '{8'h40, 8'h41, 8'h05, 8'h81, 8'h12, 8'h8F, 8'h01};
        check("reset state", {acc, psw, progAddr}, 32'h0);
        ramLoadEn = 1'b1;
        foreach (ra[i]) begin
            ramLoadAddr = ra[i];
            ramLoadData = rd[i];
            @(negedge clock);
        end
        ramLoadEn = 1'b0;
        regLoadEn = 1'b1;
        @(negedge clock);
        regLoadEn = 1'b0;
        @(negedge clock);
        check("loaded psw", psw, 8'h01);
        $display("test preload done");
    endtask

    task automatic tAdd();
        exec(8'h25, 8'h30, 2, 2, 8'h91, 8'h45);
        exec(8'h27, 8'h00, 1, 1, 8'h92, 8'h01);
        exec(8'h2B, 8'h00, 1, 1, 8'h13, 8'h85);
        exec(8'h24, 8'hF0, 2, 2, 8'h03, 8'h80);
        exec(8'h35, 8'h30, 2, 2, 8'h16, 8'h01);
        exec(8'h36, 8'h00, 1, 1, 8'hA5, 8'h40);
        exec(8'h3A, 8'h00, 1, 1, 8'hAA, 8'h00);
        exec(8'h34, 8'h56, 2, 2, 8'h00, 8'hC0);
        $display("test add done");
    endtask

    task automatic tSubb();
        exec(8'h95, 8'h30, 2, 2, 8'hED, 8'hC0);
        exec(8'h97, 8'h00, 1, 1, 8'hEB, 8'h00);
        exec(8'h9B, 8'h00, 1, 1, 8'h6A, 8'h00);
        exec(8'h94, 8'h80, 2, 2, 8'hEA, 8'h85);
        $display("test subtract done");
    endtask

    // memory results read back through adds
    task automatic tIncDec();
        exec(8'h04, 8'h00, 1, 1, 8'hEB, 8'h84);
        exec(8'h14, 8'h00, 1, 1, 8'hEA, 8'h85);
        exec(8'h05, 8'hE0, 2, 2, 8'hEB, 8'h84);
        eB = 8'h02;
        exec(8'h15, 8'hF0, 2, 2, 8'hEB, 8'h84);
        exec(8'h0A, 8'h00, 1, 1, 8'hEB, 8'h84);
        exec(8'h1B, 8'h00, 1, 1, 8'hEB, 8'h84);
        exec(8'h06, 8'h00, 1, 1, 8'hEB, 8'h84);
        exec(8'h17, 8'h00, 1, 1, 8'hEB, 8'h84);
        exec(8'h15, 8'h30, 2, 2, 8'hEB, 8'h84);
        exec(8'h2A, 8'h00, 1, 1, 8'hF1, 8'h41);
        exec(8'h2B, 8'h00, 1, 1, 8'h71, 8'h84);
        exec(8'h26, 8'h00, 1, 1, 8'h01, 8'h81);
        exec(8'h27, 8'h00, 1, 1, 8'h01, 8'h01);
        exec(8'h25, 8'h30, 2, 2, 8'h12, 8'h00);
        $display("test increment done");
    endtask

    task automatic tMulDiv();
        eB = 8'h00;
        exec(8'hA4, 8'h00, 1, 5, 8'h24, 8'h00);
        exec(8'h84, 8'h00, 1, 5, 8'h24, 8'h04);
        eB = 8'hFF;
        exec(8'h15, 8'hF0, 2, 2, 8'h24, 8'h04);
        eB = 8'h23;
        exec(8'hA4, 8'h00, 1, 5, 8'hDC, 8'h05);
        eB = 8'h0A;
        exec(8'h84, 8'h00, 1, 5, 8'h06, 8'h00);
        $display("test multiply done");
    endtask

    task automatic tDecimalPtr();
        exec(8'h24, 8'h09, 2, 2, 8'h0F, 8'h00);
        exec(8'hD4, 8'h00, 1, 1, 8'h15, 8'h01);
        exec(8'h24, 8'h99, 2, 2, 8'hAE, 8'h01);
        exec(8'hD4, 8'h00, 1, 1, 8'h14, 8'h80);
        eDp = 16'h1300;
        exec(8'hA3, 8'h00, 1, 3, 8'h14, 8'h80);
        eDp = 16'h1301;
        exec(8'hA3, 8'h00, 1, 3, 8'h14, 8'h80);
        exec(8'hE4, 8'h00, 1, 1, 8'h14, 8'h80);
        $display("test adjust and pointer done");
    endtask

    initial begin
        arst_n = 1'b0;
        run = 1'b0;
        ramLoadEn = 1'b0;
        ramLoadAddr = 8'h00;
        ramLoadData = 8'h00;
        regLoadEn = 1'b0;
        regLoadAcc = 8'h7F;
        regLoadB = 8'h03;
        regLoadPsw = 8'h00;
        regLoadPointer = 16'h12FF;
        repeat (12) @(posedge clock);
        @(negedge clock);
        arst_n = 1'b1;
        @(negedge clock);
        tPreload();
        tAdd();
        tSubb();
        tIncDec();
        tMulDiv();
        tDecimalPtr();
        closeOut();
    end
endmodule // aid_arith_decode_bench
